// ### rtl/cbc_card_dev.sv
// card control and device control registers of a two-function bridge
// assumes arst_n is the global reset; link driven by cbc_ahb_host
`timescale 1ns/1ps
`include "cbc_params.svh"

// Operation
// - ring enable bit gates ring indicate output
// - ring enable shared by both functions
// - software keeps card bits 6..3 unchanged
// - audio route bit 2 at zero drives pwm terminal
// - both routing: function 0 audio wins
// - speaker enable outputs XOR of sockets
// - speaker output drives only when enabled
// - per-socket interrupt flag set by card
// - writing one clears flag, zero keeps
// - registers reset only by global reset
// - global bits accessed via either function
// - power lock blocks power-down in D3
// - device bit 6 forces 3-V capable
// - diagnostic bit 5 writable, resets one
// - device bit 4 reads zero
// - software writes zero to test bit 3
// - bits 2..1 select interrupt signalling
// - software writes zero to bit 0
module cbc_card_dev (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        linkRst,
  cbc_link_if.dev          link,
  input  wire logic [1:0]  cardIrq,
  input  wire logic [1:0]  ringIn,
  input  wire logic [1:0]  cardSpeakerIn,
  input  wire logic [1:0]  cardAudioSignal,
  input  wire logic [1:0]  powerDownReq,
  input  wire logic        inD3,
  output logic             ringIndicateOut,
  output logic             speakerOutputO,
  output logic             speakerOutputOe,
  output logic             cardAudioPwmO,
  output logic             cardAudioPwmOe,
  output logic [1:0]       powerDownOk,
  output logic             threeVoltCapable,
  output logic             diagIoBit,
  output logic             parallelIntEn,
  output logic             serialIrqEn,
  output logic             serialPciIntEn,
  output logic [1:0]       cardInterruptFlag
);
  import cbc_pkg::*;

  //--------------------------------------------------
  // pin synchronisers
  //--------------------------------------------------
  logic [7:0] pinA_q;
  logic [7:0] pinB_q;
  logic [1:0] irqPrev_q;
  wire  [7:0] pinRaw = {cardAudioSignal, cardSpeakerIn, ringIn, cardIrq};
  wire  [1:0] irqS   = pinB_q[1:0];
  wire  [1:0] ringS  = pinB_q[3:2];
  wire  [1:0] spkS   = pinB_q[5:4];
  wire  [1:0] audS   = pinB_q[7:6];
  // rising edge of a synced card interrupt
  wire  [1:0] irqRise = irqS & ~irqPrev_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinA_q    <= '0;
      pinB_q    <= '0;
      irqPrev_q <= '0;
    end else begin
      pinA_q    <= pinRaw;
      pinB_q    <= pinA_q;
      irqPrev_q <= irqS;
    end
  end

  //--------------------------------------------------
  // link access decode
  //--------------------------------------------------
  logic       ack_q;
  cbc_byte_type rdata_q;
  // one take per request; the pending ack blocks a second
  wire  take = link.req & ~ack_q;
  wire  isCc = link.addr == `CBC_OFS_CARD_CTRL;
  wire  isDc = link.addr == `CBC_OFS_DEV_CTRL;
  wire  wrCc = take & link.wr & isCc;
  wire  wrDc = take & link.wr & isDc;

  //--------------------------------------------------
  // register state
  //--------------------------------------------------
  logic       ring_q;
  cbc_byte_type dc_q;
  cbc_byte_type cc_q [2];
  cbc_byte_type cc_d [2];
  logic [1:0] ifgClr;

  // ring enable is one bit whatever function writes it
  wire ring_d = wrCc ? link.wdata[`CBC_CC_RING] : ring_q;
  // bit 4 is not stored, all others follow the write
  wire [7:0] dc_d = wrDc ? (link.wdata & `CBC_DC_WMASK) : dc_q;

  genvar f;
  generate
    for (f = 0; f < 2; f++) begin : gFunc
      assign ifgClr[f] = wrCc & (link.func == 1'(f)) & link.wdata[`CBC_CC_IFG];
      always_comb begin
        cc_d[f] = cc_q[f];
        if (wrCc && link.func == 1'(f)) begin
          cc_d[f][`CBC_CC_RSV_HI:`CBC_CC_SPK] = link.wdata[`CBC_CC_RSV_HI:`CBC_CC_SPK];
        end
        cc_d[f][`CBC_CC_RING] = 1'b0;
        // a new card interrupt beats a clear in the same cycle
        cc_d[f][`CBC_CC_IFG] = irqRise[f] | (cc_q[f][`CBC_CC_IFG] & ~ifgClr[f]);
      end
      // only the global reset touches the stored bits
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cc_q[f] <= `CBC_CC_RST;
        end else begin
          cc_q[f] <= cc_d[f];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ring_q <= 1'b0;
      dc_q   <= `CBC_DC_RST;
    end else begin
      ring_q <= ring_d;
      dc_q   <= dc_d;
    end
  end

  //--------------------------------------------------
  // link answer
  //--------------------------------------------------
  // global bits read the same through either function
  wire [7:0] ccRead = {ring_q, cc_q[link.func][`CBC_CC_RSV_HI:0]};
  wire [7:0] rdMux  = isCc ? ccRead : (isDc ? dc_q : 8'h00);

  // the link reset restarts the handshake only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else if (linkRst) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q   <= take;
      if (take) begin
        rdata_q <= rdMux;
      end
    end
  end

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;

  //--------------------------------------------------
  // terminal functions
  //--------------------------------------------------
  // per-function enables of the shared terminals
  wire [1:0] spkEn = {cc_q[1][`CBC_CC_SPK], cc_q[0][`CBC_CC_SPK]};
  wire [1:0] audEn = {~cc_q[1][`CBC_CC_AUDIO], ~cc_q[0][`CBC_CC_AUDIO]};
  wire       spkOn = |spkEn;
  wire       audOn = |audEn;
  // function 0 has priority when both route audio
  wire       audPick = audEn[0] ? audS[0] : audS[1];
  wire [1:0] mode = dc_q[`CBC_DC_MODE_HI:`CBC_DC_MODE_LO];
  wire       lockD3 = dc_q[`CBC_DC_PWRLOCK] & inD3;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ringIndicateOut   <= 1'b0;
      speakerOutputO    <= 1'b0;
      speakerOutputOe   <= 1'b0;
      cardAudioPwmO     <= 1'b0;
      cardAudioPwmOe    <= 1'b0;
      powerDownOk       <= 2'h0;
      threeVoltCapable  <= 1'b0;
      diagIoBit         <= 1'b0;
      parallelIntEn     <= 1'b0;
      serialIrqEn       <= 1'b0;
      serialPciIntEn    <= 1'b0;
      cardInterruptFlag <= 2'h0;
    end else begin
      ringIndicateOut   <= ring_q & (|ringS);
      speakerOutputOe   <= spkOn;
      speakerOutputO    <= spkOn & (spkS[0] ^ spkS[1]);
      cardAudioPwmOe    <= audOn;
      cardAudioPwmO     <= audOn & audPick;
      powerDownOk       <= powerDownReq & {2{~lockD3}};
      threeVoltCapable  <= dc_q[`CBC_DC_CAP3V];
      diagIoBit         <= dc_q[`CBC_DC_DIAG];
      // reserved code behaves as parallel only
      parallelIntEn     <= (mode != CBC_MODE_SER_ALL);
      serialIrqEn       <= mode[1];
      serialPciIntEn    <= (mode == CBC_MODE_SER_ALL);
      cardInterruptFlag <= {cc_q[1][`CBC_CC_IFG], cc_q[0][`CBC_CC_IFG]};
    end
  end

endmodule

// ### pkg/cbc_params.svh
// constants for the card/device control register pair and its host bridge
// assumes inclusion by bare name from package and modules
`ifndef CBC_PARAMS_SVH
`define CBC_PARAMS_SVH
// device register offsets and reset values
`define CBC_OFS_CARD_CTRL 8'h91
`define CBC_OFS_DEV_CTRL  8'h92
`define CBC_CC_RST        8'h00
`define CBC_DC_RST        8'h66
// card control fields
`define CBC_CC_RING       7
`define CBC_CC_RSV_HI     6
`define CBC_CC_AUDIO      2
`define CBC_CC_SPK        1
`define CBC_CC_IFG        0
// device control fields
`define CBC_DC_PWRLOCK    7
`define CBC_DC_CAP3V      6
`define CBC_DC_DIAG       5
`define CBC_DC_WMASK      8'hEF
`define CBC_DC_MODE_HI    2
`define CBC_DC_MODE_LO    1
// host register offsets
`define CBC_H_CMD         8'h00
`define CBC_H_STATUS      8'h04
`define CBC_H_INTST       8'h08
`define CBC_H_INTMSK      8'h0C
// host field positions
`define CBC_CMD_WDATA_LO  8
`define CBC_CMD_WR        16
`define CBC_CMD_FUNC      17
`define CBC_ST_BUSY       8
`define CBC_INT_DONE      0
`define CBC_INT_REFUSED   1
`endif

// ### pkg/cbc_pkg.sv
// types shared by both ends of the card/device control link
// assumes cbc_params.svh on the include path
`include "cbc_params.svh"
package cbc_pkg;
  typedef logic [7:0] cbc_byte_type;
  typedef enum logic [1:0] {
    CBC_MODE_PARALLEL = 2'h0,
    CBC_MODE_RSVD     = 2'h1,
    CBC_MODE_SER_PAR  = 2'h2,
    CBC_MODE_SER_ALL  = 2'h3
  } cbc_int_mode_type;
  typedef enum logic [0:0] {
    CBC_HS_IDLE = 1'h0,
    CBC_HS_WAIT = 1'h1
  } cbc_host_state_type;
endpackage

// ### pkg/cbc_link_if.sv
// configuration access link between host bridge and device end
// assumes both ends on one clock; no clocking block
`timescale 1ns/1ps
interface cbc_link_if;
  logic                 req;
  logic                 wr;
  logic                 func;
  cbc_pkg::cbc_byte_type addr;
  cbc_pkg::cbc_byte_type wdata;
  logic                 ack;
  cbc_pkg::cbc_byte_type rdata;
  modport dev  (input req, wr, func, addr, wdata, output ack, rdata);
  modport host (output req, wr, func, addr, wdata, input ack, rdata);
endinterface

// ### rtl/cbc_ahb_host.sv
// AHB-Lite slave that turns software commands into link accesses
// assumes a single master, word transfers only, same clock as device
`timescale 1ns/1ps
`include "cbc_params.svh"

module cbc_ahb_host (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq,
  cbc_link_if.host         link
);
  import cbc_pkg::*;

  //--------------------------------------------------
  // bus phases
  //--------------------------------------------------
  logic               wrPend_q;
  logic [7:0]         wrAddr_q;
  cbc_host_state_type st_q;
  logic [17:0]        cmd_q;
  cbc_byte_type       rdLatch_q;
  logic [1:0]         intSt_q;
  logic [1:0]         intMsk_q;
  logic               req_q;

  wire       apValid = hsel & htrans[1] & hready & (hsize == 3'h2);
  wire [7:0] apAddr  = haddr[7:0];
  wire       rdClr   = apValid & ~hwrite & (apAddr == `CBC_H_INTST);
  wire       wrCmd   = wrPend_q & (wrAddr_q == `CBC_H_CMD);
  wire       wrMsk   = wrPend_q & (wrAddr_q == `CBC_H_INTMSK);
  wire       busy    = st_q == CBC_HS_WAIT;
  wire       start   = wrCmd & ~busy;
  wire       done    = busy & link.ack;

  wire [31:0] rdMux =
      (apAddr == `CBC_H_CMD)    ? {14'h0, cmd_q} :
      (apAddr == `CBC_H_STATUS) ? {23'h0, busy, rdLatch_q} :
      (apAddr == `CBC_H_INTST)  ? {30'h0, intSt_q} :
      (apAddr == `CBC_H_INTMSK) ? {30'h0, intMsk_q} : 32'h0;

  wire [1:0] evt     = {wrCmd & busy, done};
  // events win over a clearing read
  wire [1:0] intSt_d = evt | (intSt_q & ~{2{rdClr}});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= 8'h00;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_q  <= apValid & hwrite;
      if (apValid) begin
        wrAddr_q <= apAddr;
      end
      if (apValid && !hwrite) begin
        hrdata <= rdMux;
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  //--------------------------------------------------
  // command engine and interrupt
  //--------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q      <= CBC_HS_IDLE;
      cmd_q     <= 18'h0;
      req_q     <= 1'b0;
      rdLatch_q <= 8'h00;
      intSt_q   <= 2'h0;
      intMsk_q  <= 2'h0;
      irq       <= 1'b0;
    end else begin
      case (st_q)
        CBC_HS_IDLE: begin
          if (start) begin
            cmd_q <= hwdata[17:0];
            req_q <= 1'b1;
            st_q  <= CBC_HS_WAIT;
          end
        end
        CBC_HS_WAIT: begin
          if (link.ack) begin
            req_q     <= 1'b0;
            rdLatch_q <= link.rdata;
            st_q      <= CBC_HS_IDLE;
          end
        end
        default: begin
          req_q <= 1'b0;
          st_q  <= CBC_HS_IDLE;
        end
      endcase
      if (wrMsk) begin
        intMsk_q <= hwdata[1:0];
      end
      intSt_q <= intSt_d;
      irq     <= |(intSt_q & intMsk_q);
    end
  end

  assign link.req   = req_q;
  assign link.wr    = cmd_q[`CBC_CMD_WR];
  assign link.func  = cmd_q[`CBC_CMD_FUNC];
  assign link.addr  = cmd_q[7:0];
  assign link.wdata = cmd_q[`CBC_CMD_WDATA_LO +: 8];

endmodule

// ### verif/cbc_link_chk.sv
// concurrent checks on the link between host bridge and device end
// assumes instantiation beside the interface; one clock, arst_n global reset
`timescale 1ns/1ps
`include "cbc_params.svh"
module cbc_link_chk (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  req,
  input  wire logic                  wr,
  input  wire logic                  func,
  input  wire cbc_pkg::cbc_byte_type addr,
  input  wire cbc_pkg::cbc_byte_type wdata,
  input  wire logic                  ack,
  input  wire cbc_pkg::cbc_byte_type rdata
);
  import cbc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ----
  // shadow of written contents
  // ----
  cbc_byte_type       dcSh_q;
  logic [1:0][7:0]    ccSh_q;
  wire                wrDone = ack && wr;
  wire                rdDone = ack && !wr;
  wire                isDc   = addr == `CBC_OFS_DEV_CTRL;
  wire                isCc   = addr == `CBC_OFS_CARD_CTRL;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dcSh_q <= `CBC_DC_RST;
      ccSh_q <= {2{`CBC_CC_RST}};
    end else if (wrDone && isDc) begin
      dcSh_q <= wdata & `CBC_DC_WMASK;
    end else if (wrDone && isCc) begin
      ccSh_q[func]     <= wdata;
      ccSh_q[!func][7] <= wdata[7];
    end
  end
  // ----
  // handshake and read-back checks
  // ----
  sequence taken_s; req && !ack; endsequence
  sequence answer_s; ack ##1 !ack; endsequence
  link_answer_a: assert property (taken_s |=> answer_s)
    else $error("link ack not one cycle after request");
  req_release_a: assert property (ack |=> !req)
    else $error("request held after ack");
  fields_hold_a: assert property (taken_s |=> $stable({wr, func, addr, wdata}))
    else $error("link fields moved while pending");
  stray_ack_a: assert property (!req |=> !ack)
    else $error("ack without request");
  rsvd_zero_a: assert property (rdDone && isDc |-> !rdata[4])
    else $error("device bit 4 reads one");
  unmapped_zero_a: assert property (rdDone && !isDc && !isCc |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  dev_ctrl_a: assert property (rdDone && isDc |-> rdata == dcSh_q)
    else $error("device control read-back wrong");
  ring_share_a: assert property (rdDone && isCc |-> rdata[7] == ccSh_q[func][7])
    else $error("ring enable not shared");
  card_bits_a: assert property (rdDone && isCc |-> rdata[6:1] == ccSh_q[func][6:1])
    else $error("card control bits wrong");
endmodule

// ### verif/cardbus_card_device_control_tb_top.sv
// bench: AHB master, device pins, scoreboard queues and verdict
// assumes the two design ends joined by cbc_link_if on one clock
`timescale 1ns/1ps
`include "cbc_params.svh"
module cardbus_card_device_control_tb_top;
  import cbc_pkg::*;
  typedef struct packed {logic [31:0] m; logic [31:0] e;} cbc_note_type;
  logic         clk = 1'b0, arst_n = 1'b0, linkRst = 1'b0, inD3 = 1'b0, hsel = 1'b1, hwrite = 1'b0, dphRd = 1'b0;
  logic [1:0]   htrans = 2'h0, cardIrq = 2'h0, ringIn = 2'h0, spk = 2'h0, aud = 2'h0, pdReq = 2'h0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic         hreadyout, hresp, irq, ringO, spkO, spkOe, audO, audOe, v3, diag, parEn, sirqEn, spciEn;
  logic [1:0]   pdOk, flag;
  int           mismatches = 0, cmp_count = 0, seed = 82551;
  cbc_note_type rdQ[$], pinQ[$];
  logic [19:0]  tbl [4] = '{20'hACE02, 20'h5DB84, 20'hF7C86, 20'hFD084};
  wire  [31:0]  pins = {17'h0, irq, ringO, spkOe, spkO, audOe, audO, pdOk, v3, diag, parEn, sirqEn, spciEn, flag};
  cbc_link_if link ();
  always #2 clk = ~clk;
  cbc_card_dev i_cbc_card_dev (.clk(clk), .arst_n(arst_n), .linkRst(linkRst), .link(link.dev), .cardIrq(cardIrq),
    .ringIn(ringIn), .cardSpeakerIn(spk), .cardAudioSignal(aud), .powerDownReq(pdReq), .inD3(inD3),
    .ringIndicateOut(ringO), .speakerOutputO(spkO), .speakerOutputOe(spkOe), .cardAudioPwmO(audO),
    .cardAudioPwmOe(audOe), .powerDownOk(pdOk), .threeVoltCapable(v3), .diagIoBit(diag),
    .parallelIntEn(parEn), .serialIrqEn(sirqEn), .serialPciIntEn(spciEn), .cardInterruptFlag(flag));
  cbc_ahb_host i_cbc_ahb_host (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(link.host));
  cbc_link_chk i_cbc_link_chk (.clk(clk), .arst_n(arst_n), .req(link.req), .wr(link.wr), .func(link.func),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    if (!w) rdQ.push_back('{m, e});
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // link access through the command register, done polled in the event register
  task automatic dev(input logic w, input logic f, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] m, input logic [7:0] e);
    int n;
    ahb(1'b1, `CBC_H_CMD, {14'h0, f, w, d, a}, 32'h0, 32'h0);
    for (n = 0; n < 50; n++) begin
      ahb(1'b0, `CBC_H_INTST, 32'h0, 32'h0, 32'h0);
      if (rd[`CBC_INT_DONE] === 1'b1) break;
    end
    check({31'h0, rd[`CBC_INT_DONE]}, 32'h1);
    if (!w) ahb(1'b0, `CBC_H_STATUS, 32'h0, {24'h0, m}, {24'h0, e});
  endtask
  // pins pass two sync stages and a register before they settle
  task automatic pin(input logic [14:0] m, input logic [14:0] e);
    repeat (5) @(posedge clk);
    pinQ.push_back('{{17'h0, m}, {17'h0, e}});
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    cbc_note_type n;
    if (dphRd && rdQ.size() > 0) begin
      n = rdQ.pop_front();
      if (n.m != 32'h0) check(hrdata & n.m, n.e & n.m);
      check({31'h0, hresp}, 32'h0);
    end
    if (pinQ.size() > 0) begin
      n = pinQ.pop_front();
      check(pins & n.m, n.e & n.m);
    end
    dphRd <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  // about 300 cycles needed, 20000 allowed
  initial begin
    #80000;
    mismatches++;
    finish_test;
  end
  // ----
  // scenarios
  // ----
  initial begin
    logic [7:0]  d;
    logic [31:0] r;
    logic [19:0] t;
    int          n;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    pin(15'h7FFF, 15'h046C);
    dev(1'b0, 1'b1, `CBC_OFS_DEV_CTRL, 8'h0, 8'hFF, `CBC_DC_RST);
    dev(1'b0, 1'b1, `CBC_OFS_CARD_CTRL, 8'h0, 8'hFF, `CBC_CC_RST);
    $display("reset values done");
    pdReq <= 2'h3;
    for (int m = 0; m < 4; m++) begin
      r = $random(seed);
      d = {r[7:5], 2'h2, m[1:0], 1'b0};
      inD3 <= r[8];
      dev(1'b1, 1'b0, `CBC_OFS_DEV_CTRL, d, 8'h0, 8'h0);
      dev(1'b0, r[9], `CBC_OFS_DEV_CTRL, 8'h0, 8'hFF, d & `CBC_DC_WMASK);
      pin(15'h01FC, {6'h0, (d[7] & r[8]) ? 2'h0 : 2'h3, d[6:5], m != 3, m[1], m == 3, 2'h0});
    end
    $display("device control done");
    for (int i = 0; i < 4; i++) begin
      t = tbl[i];
      dev(1'b1, t[19], `CBC_OFS_CARD_CTRL, t[7:0], 8'h0, 8'h0);
      {ringIn, spk, aud} <= t[18:13];
      pin(15'h3E00, {1'b0, t[12:8], 9'h0});
    end
    dev(1'b0, 1'b1, `CBC_OFS_CARD_CTRL, 8'h0, 8'hFE, 8'h84);
    $display("card routing done");
    cardIrq <= 2'h1;
    pin(15'h0003, 15'h0001);
    dev(1'b0, 1'b1, `CBC_OFS_CARD_CTRL, 8'h0, 8'h01, 8'h00);
    dev(1'b1, 1'b0, `CBC_OFS_CARD_CTRL, 8'h04, 8'h0, 8'h0);
    dev(1'b0, 1'b0, `CBC_OFS_CARD_CTRL, 8'h0, 8'h01, 8'h01);
    dev(1'b1, 1'b0, `CBC_OFS_CARD_CTRL, 8'h05, 8'h0, 8'h0);
    dev(1'b0, 1'b0, `CBC_OFS_CARD_CTRL, 8'h0, 8'hFF, 8'h04);
    cardIrq <= 2'h3;
    pin(15'h0003, 15'h0002);
    $display("interrupt flag done");
    for (int k = 1; k < 3; k++) begin
      ahb(1'b1, `CBC_H_INTMSK, k, 32'h0, 32'h0);
      ahb(1'b1, `CBC_H_CMD, 32'h92, 32'h0, 32'h0);
      if (k == 2) ahb(1'b1, `CBC_H_CMD, 32'h92, 32'h0, 32'h0);
      for (n = 0; n < 50 && irq !== 1'b1; n++) @(posedge clk);
      pin(15'h4000, 15'h4000);
      ahb(1'b0, `CBC_H_INTST, 32'h0, k, k);
      ahb(1'b0, `CBC_H_INTST, 32'h0, 32'h3, 32'h0);
      pin(15'h4000, 15'h0000);
    end
    ahb(1'b1, 8'h40, 32'h3, 32'h0, 32'h0);
    ahb(1'b0, `CBC_H_INTMSK, 32'h0, 32'h3, 32'h2);
    dev(1'b0, 1'b0, 8'h50, 8'h0, 8'hFF, 8'h00);
    ahb(1'b0, `CBC_H_CMD, 32'h0, 32'h3FFFF, 32'h50);
    $display("host events done");
    linkRst <= 1'b1;
    @(posedge clk);
    linkRst <= 1'b0;
    dev(1'b0, 1'b0, `CBC_OFS_DEV_CTRL, 8'h0, 8'hFF, d & `CBC_DC_WMASK);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    dev(1'b0, 1'b0, `CBC_OFS_DEV_CTRL, 8'h0, 8'hFF, `CBC_DC_RST);
    $display("reset sources done");
    finish_test;
  end
endmodule
